// ---- hw/pprl_regs.svh ----
/*
  Register offsets, key values, field positions, reset values and option bit
  positions of the pin routing lock block. Assumes inclusion by bare name.
*/
`ifndef PPRL_REGS_SVH
`define PPRL_REGS_SVH

`define PPRL_LOCK_OFS 32'h0000_0000
`define PPRL_SEL_PAGE 26'h000_0001
`define PPRL_IDX_W 4
`define PPRL_SEL_W 5
`define PPRL_KEY1 8'h55
`define PPRL_KEY2 8'haa
`define PPRL_LOCK_BIT 0
`define PPRL_LOCK_RST 1'b0
`define PPRL_CW2_W 14
`define PPRL_CW2_ONESHOT_BIT 11
`define PPRL_ONESHOT_RST 1'b1
`define PPRL_CODE_PC0 5'h10
`define PPRL_CODE_PC6 5'h16
`define PPRL_CODE_PB4 5'h0c
`define PPRL_CODE_PB7 5'h0f
`define PPRL_CODE_PA1 5'h01
`define PPRL_CODE_PA5 5'h05

`endif

// ---- hw/pprl_pkg.sv ----
/*
  Types of the pin routing lock block: key state and top-level state.
  Assumes pprl_regs.svh is on the include path.
*/
`include "pprl_regs.svh"
package pprl_pkg;

  typedef enum logic [2:0] {
    PPRL_KEY_IDLE = 3'b001,
    PPRL_KEY_HALF = 3'b010,
    PPRL_KEY_FULL = 3'b100
  } pprl_key_t;

  typedef struct packed {
    logic dph_valid;
    logic dph_write;
    logic dph_lock;
    logic dph_sel;
    logic [`PPRL_IDX_W-1:0] dph_idx;
    pprl_key_t key;
    logic lock_flag;
    logic used;
    logic oneshot;
    logic cfg_taken;
    logic [7:0] pa_meta;
    logic [7:0] pa_sync;
    logic [7:0] pb_meta;
    logic [7:0] pb_sync;
    logic [7:0] pc_meta;
    logic [7:0] pc_sync;
  } pprl_state_t;

  localparam pprl_state_t PPRL_STATE_RST = '{
    key: PPRL_KEY_IDLE,
    lock_flag: `PPRL_LOCK_RST,
    oneshot: `PPRL_ONESHOT_RST,
    default: '0
  };

endpackage : pprl_pkg

// ---- hw/pprl_sel_mem.sv ----
/*
  Selection register file: one five-bit pin field per peripheral input.
  Assumes one clock, power-on reset on nrst, writes already filtered by lock.
*/
`timescale 1ns/1ps
`include "pprl_regs.svh"
module pprl_sel_mem #(
  parameter int N_INPUTS = 16,
  parameter logic [N_INPUTS*`PPRL_SEL_W-1:0] SEL_DEFAULTS = '0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [`PPRL_IDX_W-1:0] waddr,
  input wire logic [`PPRL_SEL_W-1:0] wdata,
  input wire logic [`PPRL_IDX_W-1:0] raddr,
  output logic [`PPRL_SEL_W-1:0] rdata,
  output logic [N_INPUTS*`PPRL_SEL_W-1:0] sel_flat
);

  typedef struct packed {
    logic [N_INPUTS-1:0][`PPRL_SEL_W-1:0] sel;
    logic [`PPRL_SEL_W-1:0] rdata;
  } pprl_mem_t;

  localparam pprl_mem_t MEM_RST = '{sel: SEL_DEFAULTS, rdata: '0};

  pprl_mem_t st;
  pprl_mem_t next_st;

  // one field per input, no sleep term
  always_comb begin
    next_st = st;
    if (we) begin
      next_st.sel[waddr] = wdata;
    end
    if (we && waddr == raddr) begin
      next_st.rdata = wdata;
    end else if (32'(raddr) < N_INPUTS) begin
      next_st.rdata = st.sel[raddr];
    end else begin
      next_st.rdata = '0;
    end
  end

  // only power-on reset restores defaults
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= MEM_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign sel_flat = st.sel;

  a_mem_write_lands: assert property (@(posedge clk) disable iff (!nrst)
    we |=> st.sel[$past(waddr)] == $past(wdata))
    else $error("selection write not stored");

endmodule : pprl_sel_mem

// ---- hw/pprl_in_mux.sv ----
/*
  Pin-to-peripheral input routing, one registered output per input.
  Assumes port levels already synchronised to clk.
*/
`timescale 1ns/1ps
`include "pprl_regs.svh"
module pprl_in_mux #(
  parameter int N_INPUTS = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [N_INPUTS*`PPRL_SEL_W-1:0] sel_flat,
  input wire logic [7:0] porta,
  input wire logic [7:0] portb,
  input wire logic [7:0] portc,
  output logic [N_INPUTS-1:0] periph_in
);

  typedef struct packed {
    logic [N_INPUTS-1:0] route;
  } pprl_mux_t;

  pprl_mux_t st;
  pprl_mux_t next_st;
  logic [N_INPUTS-1:0] route_w;

  // code to pin decode, reserved codes give low
  function automatic logic pin_route(input logic [`PPRL_SEL_W-1:0] code, input logic [7:0] pa,
                                     input logic [7:0] pb, input logic [7:0] pc);
    logic r;
    r = 1'b0;
    if (code >= `PPRL_CODE_PC0 && code <= `PPRL_CODE_PC6) begin
      r = pc[3'(code - `PPRL_CODE_PC0)];
    end else if (code >= `PPRL_CODE_PB4 && code <= `PPRL_CODE_PB7) begin
      r = pb[3'(code - `PPRL_CODE_PB4) + 3'd4];
    end else if (code >= `PPRL_CODE_PA1 && code <= `PPRL_CODE_PA5) begin
      r = pa[3'(code)];
    end
    return r;
  endfunction : pin_route

  genvar gi;
  generate
    for (gi = 0; gi < N_INPUTS; gi++) begin : g_route
      assign route_w[gi] = pin_route(sel_flat[gi*`PPRL_SEL_W +: `PPRL_SEL_W], porta, portb, portc);
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.route = route_w;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign periph_in = st.route;

  a_map_portc: assert property (@(posedge clk) disable iff (!nrst)
    sel_flat[`PPRL_SEL_W-1:0] == `PPRL_CODE_PC0 |=> periph_in[0] == $past(portc[0]))
    else $error("port C pin 0 not routed");

  a_map_portb: assert property (@(posedge clk) disable iff (!nrst)
    sel_flat[`PPRL_SEL_W-1:0] == `PPRL_CODE_PB7 |=> periph_in[0] == $past(portb[7]))
    else $error("port B pin 7 not routed");

  a_map_porta: assert property (@(posedge clk) disable iff (!nrst)
    sel_flat[`PPRL_SEL_W-1:0] == `PPRL_CODE_PA5 |=> periph_in[0] == $past(porta[5]))
    else $error("port A pin 5 not routed");

  a_map_reserved: assert property (@(posedge clk) disable iff (!nrst)
    sel_flat[`PPRL_SEL_W-1:0] == 5'h00 |=> !periph_in[0])
    else $error("reserved code drives input");

endmodule : pprl_in_mux

// ---- hw/pprl_top.sv ----
/*
  Pin routing lock block: AHB-Lite register slave, unlock key, lock flag,
  one-shot option, per-input selection registers and input routing.
  Assumes it is the only slave on its bus, so HREADYOUT is the bus HREADY,
  and that CONFIG_WORD2 is static after power-on.
*/
`timescale 1ns/1ps
`include "pprl_regs.svh"
module pprl_top
  import pprl_pkg::*;
#(
  parameter int N_INPUTS = 16,
  parameter logic [N_INPUTS*`PPRL_SEL_W-1:0] SEL_DEFAULTS = '0
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic SOFT_RST,
  input wire logic [`PPRL_CW2_W-1:0] CONFIG_WORD2,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  input wire logic [7:0] PORTA_IN,
  input wire logic [7:0] PORTB_IN,
  input wire logic [7:0] PORTC_IN,
  output logic [N_INPUTS-1:0] PERIPH_IN,
  output logic ROUTING_LOCKED
);

  pprl_state_t st;
  pprl_state_t next_st;

  logic take;
  logic addr_lock;
  logic addr_sel;
  logic lock_wr;
  logic lock_cmd;
  logic lock_ok;
  logic sel_wr;
  logic mem_we;
  logic [`PPRL_SEL_W-1:0] mem_rdata;
  logic [N_INPUTS*`PPRL_SEL_W-1:0] sel_flat;
  logic [7:0] key_byte;

  // address decode of the address phase
  assign take = HSEL && HTRANS[1] && HREADY;
  assign addr_lock = HADDR == `PPRL_LOCK_OFS;
  assign addr_sel = HADDR[31:6] == `PPRL_SEL_PAGE && HADDR[1:0] == 2'b00
                    && 32'(HADDR[5:2]) < N_INPUTS;

  // data phase decode
  assign key_byte = HWDATA[7:0];
  assign lock_wr = st.dph_valid && st.dph_write && st.dph_lock;
  assign lock_cmd = lock_wr && st.key == PPRL_KEY_FULL;
  assign lock_ok = !(st.oneshot && st.used);
  assign sel_wr = st.dph_valid && st.dph_write && st.dph_sel;
  assign mem_we = sel_wr && !st.lock_flag;

  always_comb begin
    next_st = st;
    // two-flop synchronisers for the port pins
    next_st.pa_meta = PORTA_IN;
    next_st.pa_sync = st.pa_meta;
    next_st.pb_meta = PORTB_IN;
    next_st.pb_sync = st.pb_meta;
    next_st.pc_meta = PORTC_IN;
    next_st.pc_sync = st.pc_meta;
    // option caught once after reset release
    if (!st.cfg_taken) begin
      next_st.oneshot = CONFIG_WORD2[`PPRL_CW2_ONESHOT_BIT];
      next_st.cfg_taken = 1'b1;
    end
    // unlock key walk, any other access discards it
    if (st.dph_valid) begin
      if (lock_wr) begin
        unique case (st.key)
          PPRL_KEY_IDLE: begin
            next_st.key = (key_byte == `PPRL_KEY1) ? PPRL_KEY_HALF : PPRL_KEY_IDLE;
          end
          PPRL_KEY_HALF: begin
            if (key_byte == `PPRL_KEY2) begin
              next_st.key = PPRL_KEY_FULL;
            end else if (key_byte == `PPRL_KEY1) begin
              next_st.key = PPRL_KEY_HALF;
            end else begin
              next_st.key = PPRL_KEY_IDLE;
            end
          end
          PPRL_KEY_FULL: begin
            next_st.key = PPRL_KEY_IDLE;
            if (lock_ok) begin
              next_st.lock_flag = HWDATA[`PPRL_LOCK_BIT];
              next_st.used = st.used || (st.oneshot && HWDATA[`PPRL_LOCK_BIT]);
            end
          end
          default: begin
            next_st.key = PPRL_KEY_IDLE;
          end
        endcase
      end else begin
        next_st.key = PPRL_KEY_IDLE;
      end
    end
    // address phase capture
    if (HREADY) begin
      next_st.dph_valid = take;
      next_st.dph_write = HWRITE;
      next_st.dph_lock = addr_lock;
      next_st.dph_sel = addr_sel;
      next_st.dph_idx = HADDR[5:2];
    end
    // other resets: lock logic restarts, selections kept
    if (SOFT_RST) begin
      next_st.key = PPRL_KEY_IDLE;
      next_st.lock_flag = `PPRL_LOCK_RST;
      next_st.used = 1'b0;
      next_st.cfg_taken = 1'b0;
      next_st.dph_valid = 1'b0;
    end
  end

  // power-on reset clears the lock flag
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st <= PPRL_STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  pprl_sel_mem #(
    .N_INPUTS(N_INPUTS),
    .SEL_DEFAULTS(SEL_DEFAULTS)
  ) u_mem (
    .clk(CLK),
    .nrst(NRST),
    .we(mem_we),
    .waddr(st.dph_idx),
    .wdata(HWDATA[`PPRL_SEL_W-1:0]),
    .raddr(HADDR[5:2]),
    .rdata(mem_rdata),
    .sel_flat(sel_flat)
  );

  pprl_in_mux #(
    .N_INPUTS(N_INPUTS)
  ) u_mux (
    .clk(CLK),
    .nrst(NRST),
    .sel_flat(sel_flat),
    .porta(st.pa_sync),
    .portb(st.pb_sync),
    .portc(st.pc_sync),
    .periph_in(PERIPH_IN)
  );

  // read data regardless of lock or option
  always_comb begin
    HRDATA = 32'h0000_0000;
    if (st.dph_valid && !st.dph_write && st.dph_lock) begin
      HRDATA[`PPRL_LOCK_BIT] = st.lock_flag;
    end else if (st.dph_valid && !st.dph_write && st.dph_sel) begin
      HRDATA[`PPRL_SEL_W-1:0] = mem_rdata;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign ROUTING_LOCKED = st.lock_flag;

  logic sel_rd;
  assign sel_rd = st.dph_valid && !st.dph_write && st.dph_sel;

  a_key_before_change: assert property (@(posedge CLK) disable iff (!NRST)
    (st.lock_flag != $past(st.lock_flag)) && !$past(SOFT_RST) |-> $past(st.key) == PPRL_KEY_FULL)
    else $error("lock flag changed without key");

  a_key_order: assert property (@(posedge CLK) disable iff (!NRST || SOFT_RST)
    st.key == PPRL_KEY_FULL && $past(st.key) != PPRL_KEY_FULL
      |-> $past(st.key) == PPRL_KEY_HALF && $past(key_byte) == `PPRL_KEY2)
    else $error("key completed out of order");

  a_lock_blocks_write: assert property (@(posedge CLK) disable iff (!NRST)
    sel_wr && st.lock_flag && !SOFT_RST |=> $stable(sel_flat))
    else $error("write landed while locked");

  a_open_takes_write: assert property (@(posedge CLK) disable iff (!NRST)
    sel_wr && !st.lock_flag |=> sel_flat[$past(st.dph_idx)*`PPRL_SEL_W +: `PPRL_SEL_W]
                                == $past(HWDATA[`PPRL_SEL_W-1:0]))
    else $error("write lost while unlocked");

  a_option_source: assert property (@(posedge CLK) disable iff (!NRST)
    $rose(st.cfg_taken) |-> st.oneshot == $past(CONFIG_WORD2[`PPRL_CW2_ONESHOT_BIT]))
    else $error("one-shot option not from config word");

  a_oneshot_freeze: assert property (@(posedge CLK) disable iff (!NRST)
    st.used && st.oneshot && !SOFT_RST |=> st.lock_flag == $past(st.lock_flag))
    else $error("lock flag moved after one-shot use");

  a_multi_change: assert property (@(posedge CLK) disable iff (!NRST)
    lock_cmd && !st.oneshot && !SOFT_RST |=> st.lock_flag == $past(HWDATA[`PPRL_LOCK_BIT]))
    else $error("lock change refused without one-shot");

  a_lock_readback: assert property (@(posedge CLK) disable iff (!NRST)
    st.dph_valid && !st.dph_write && st.dph_lock |-> HRDATA == {31'h0000_0000, st.lock_flag})
    else $error("lock readback wrong");

  a_sel_readback: assert property (@(posedge CLK) disable iff (!NRST)
    sel_rd |-> HRDATA[`PPRL_SEL_W-1:0] == sel_flat[st.dph_idx*`PPRL_SEL_W +: `PPRL_SEL_W])
    else $error("selection readback wrong");

  a_upper_zero: assert property (@(posedge CLK) disable iff (!NRST)
    sel_rd |-> HRDATA[31:`PPRL_SEL_W] == 27'h000_0000)
    else $error("upper selection bits not zero");

  a_soft_keep: assert property (@(posedge CLK) disable iff (!NRST)
    SOFT_RST && !mem_we |=> $stable(sel_flat) && !st.lock_flag)
    else $error("soft reset disturbed selections");

  a_break_key: assert property (@(posedge CLK) disable iff (!NRST)
    st.dph_valid && !lock_wr && st.key != PPRL_KEY_IDLE |=> st.key == PPRL_KEY_IDLE
                                                          && $stable(st.lock_flag))
    else $error("broken key not discarded");

  c_lock_set: cover property (@(posedge CLK) disable iff (!NRST)
    $rose(st.lock_flag));

  c_write_blocked: cover property (@(posedge CLK) disable iff (!NRST)
    sel_wr && st.lock_flag);

  c_unlock_again: cover property (@(posedge CLK) disable iff (!NRST)
    $fell(st.lock_flag) && !$past(SOFT_RST));

  c_oneshot_used: cover property (@(posedge CLK) disable iff (!NRST)
    lock_cmd && st.used && st.oneshot);

endmodule : pprl_top

// ---- sim/peripheral_pin_select_lock_tb.sv ----
/*
  Self-checking bench of the pin routing lock block: bus access, key, lock,
  one-shot option, resets and input routing.
  Assumes pprl_top is the only slave, so its hreadyout is the bus hready.
*/
`timescale 1ns/1ps
`include "pprl_regs.svh"
module peripheral_pin_select_lock_tb;
  localparam logic [31:0] LOCK_A = `PPRL_LOCK_OFS;
  localparam logic [31:0] SEL_A = 32'h0000_0040;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic soft_rst = 1'b0;
  logic [`PPRL_CW2_W-1:0] cfg = '0;
  logic hsel = 1'b1;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = '0;
  logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [7:0] porta = '0;
  logic [7:0] portb = '0;
  logic [7:0] portc = '0;
  logic [15:0] periph_in;
  logic routing_locked;
  int mismatches = 0;
  int compares = 0;

  always #5 clk = ~clk;
  assign hready = hreadyout;

  pprl_top #(.N_INPUTS(16)) dut (
    .CLK(clk), .NRST(nrst), .SOFT_RST(soft_rst), .CONFIG_WORD2(cfg),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hreadyout),
    .HRESP(hresp), .HRDATA(hrdata), .PORTA_IN(porta), .PORTB_IN(portb),
    .PORTC_IN(portc), .PERIPH_IN(periph_in), .ROUTING_LOCKED(routing_locked)
  );

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one edge, then further edges until hready is seen high
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        mismatches++;
        $display("unexpected hready expected 1 seen stuck low");
        wrap_up();
      end
      @(posedge clk);
    end
  endtask : wait_rdy

  // single word transfer, entered and left just after a rising edge
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr

  task automatic rd_chk(input string name, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    chk(name, exp, r);
  endtask : rd_chk

  task automatic lock_chk(input logic exp);
    rd_chk("lock reg", LOCK_A, {31'h0, exp});
    chk("lock port", {31'h0, exp}, {31'h0, routing_locked});
  endtask : lock_chk

  // key writes issued back to back, nothing in between
  task automatic key_set(input logic v);
    wr(LOCK_A, 32'h55);
    wr(LOCK_A, 32'haa);
    wr(LOCK_A, {31'h0, v});
  endtask : key_set

  task automatic do_reset(input logic por);
    if (por) begin
      nrst <= 1'b0;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
    end else begin
      soft_rst <= 1'b1;
      @(posedge clk);
      soft_rst <= 1'b0;
    end
    @(posedge clk);
  endtask : do_reset

  task automatic t_defaults;
    lock_chk(1'b0);
    rd_chk("sel default", SEL_A, 32'h0);
    rd_chk("unmapped", 32'h0000_0020, 32'h0);
  endtask : t_defaults

  task automatic t_sel_rw;
    wr(SEL_A + 32'h4, 32'hffff_ff13);
    rd_chk("sel upper bits", SEL_A + 32'h4, 32'h13);
    wr(SEL_A + 32'h3c, 32'h05);
    rd_chk("sel last", SEL_A + 32'h3c, 32'h05);
    {portc, porta} <= {8'h08, 8'h20};
    repeat (4) @(posedge clk);
    chk("routed idx1", 32'h1, {31'h0, periph_in[1]});
    chk("routed idx15", 32'h1, {31'h0, periph_in[15]});
    {portc, porta} <= 16'h0000;
    repeat (4) @(posedge clk);
    chk("routed idx15 low", 32'h0, {31'h0, periph_in[15]});
  endtask : t_sel_rw

  // every documented code: the one selected pin high, then the only one low
  task automatic t_route;
    logic [23:0] pins;
    for (int c = 1; c <= 22; c++) begin
      if (c >= 6 && c <= 11) continue;
      wr(SEL_A, c);
      pins = 24'h1 << c;
      {portc, portb, porta} <= pins;
      repeat (4) @(posedge clk);
      chk("routed high", 32'h1, {31'h0, periph_in[0]});
      {portc, portb, porta} <= ~pins;
      repeat (4) @(posedge clk);
      chk("routed low", 32'h0, {31'h0, periph_in[0]});
    end
  endtask : t_route

  task automatic t_lock_cycle;
    key_set(1'b1);
    lock_chk(1'b1);
    wr(SEL_A, 32'h01);
    rd_chk("sel locked", SEL_A, 32'h16);
    key_set(1'b0);
    lock_chk(1'b0);
    wr(SEL_A, 32'h01);
    rd_chk("sel unlocked", SEL_A, 32'h01);
    key_set(1'b1);
    lock_chk(1'b1);
    key_set(1'b0);
    lock_chk(1'b0);
  endtask : t_lock_cycle

  task automatic t_broken_key;
    logic [31:0] r;
    wr(LOCK_A, 32'h55);
    xfer(1'b0, LOCK_A, 32'h0, r);
    wr(LOCK_A, 32'haa);
    wr(LOCK_A, 32'h1);
    lock_chk(1'b0);
    wr(LOCK_A, 32'h55);
    wr(SEL_A, 32'h02);
    wr(LOCK_A, 32'haa);
    wr(LOCK_A, 32'h1);
    lock_chk(1'b0);
    wr(LOCK_A, 32'h55);
    wr(LOCK_A, 32'h12);
    wr(LOCK_A, 32'haa);
    wr(LOCK_A, 32'h1);
    lock_chk(1'b0);
    wr(LOCK_A, 32'haa);
    wr(LOCK_A, 32'h1);
    lock_chk(1'b0);
    wr(LOCK_A, 32'h55);
    repeat (3) @(posedge clk);
    wr(LOCK_A, 32'haa);
    wr(LOCK_A, 32'h1);
    lock_chk(1'b1);
    key_set(1'b0);
  endtask : t_broken_key

  task automatic t_resets;
    wr(SEL_A, 32'h05);
    key_set(1'b1);
    do_reset(1'b0);
    lock_chk(1'b0);
    rd_chk("sel soft reset", SEL_A, 32'h05);
    do_reset(1'b1);
    rd_chk("sel power reset", SEL_A, 32'h0);
    lock_chk(1'b0);
  endtask : t_resets

  task automatic t_one_shot;
    cfg[`PPRL_CW2_ONESHOT_BIT] <= 1'b1;
    do_reset(1'b1);
    key_set(1'b0);
    wr(SEL_A, 32'h0c);
    key_set(1'b1);
    lock_chk(1'b1);
    key_set(1'b0);
    lock_chk(1'b1);
    wr(SEL_A, 32'h03);
    rd_chk("sel one shot", SEL_A, 32'h0c);
    do_reset(1'b0);
    lock_chk(1'b0);
    key_set(1'b1);
    lock_chk(1'b1);
    cfg[`PPRL_CW2_ONESHOT_BIT] <= 1'b0;
    do_reset(1'b1);
  endtask : t_one_shot

  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_defaults();
    t_sel_rw();
    t_route();
    t_lock_cycle();
    t_broken_key();
    t_resets();
    t_one_shot();
    wrap_up();
  end
endmodule : peripheral_pin_select_lock_tb
